// >>> common/msp_defines.svh
// timing constants of the motion sensor serial port and power-down logic
`ifndef MSP_DEFINES_SVH
`define MSP_DEFINES_SVH
`define MSP_CLK_PERIOD_NS 50
`define MSP_NS2CYC_UP(ns) (((ns) + `MSP_CLK_PERIOD_NS - 1) / `MSP_CLK_PERIOD_NS)
`define MSP_PREP_NS 100000
`define MSP_PREP_CYC `MSP_NS2CYC_UP(`MSP_PREP_NS)
`define MSP_PDR_NS 100000
`define MSP_PDR_CYC `MSP_NS2CYC_UP(`MSP_PDR_NS)
`define MSP_PDW_NS 700000
`define MSP_PDW_CYC `MSP_NS2CYC_UP(`MSP_PDW_NS)
`define MSP_COMPUTE_NS 3200000
`define MSP_COMPUTE_CYC `MSP_NS2CYC_UP(`MSP_COMPUTE_NS)
`define MSP_QUAD_BASE_NS 705000
`define MSP_QUAD_BASE_CYC `MSP_NS2CYC_UP(`MSP_QUAD_BASE_NS)
`define MSP_QUAD_FRAMES 75
`define MSP_FRAME_RATE 1500
`define MSP_FRAME_CYC ((1000000000 / `MSP_FRAME_RATE) / `MSP_CLK_PERIOD_NS)
`define MSP_WD_MS 900
`define MSP_WD_CYC ((`MSP_WD_MS * 1000000) / `MSP_CLK_PERIOD_NS)
`define MSP_CMD_WRITE_BIT 7
`define MSP_LAST_BIT 4'h7
`endif

// >>> common/msp_pkg.sv
// types of the serial port transaction engine
package msp_pkg;
  typedef enum logic [2:0] {
    MSP_ST_ADDR = 3'b000,
    MSP_ST_WDATA = 3'b001,
    MSP_ST_PREP = 3'b010,
    MSP_ST_RDATA = 3'b011,
    MSP_ST_RHOLD = 3'b100
  } msp_state_e;
endpackage : msp_pkg

// >>> verilog/msp_power_seq.sv
// power-down pulse timing, sleep and wake sequencing, frame timing
`include "msp_defines.svh"
module msp_power_seq #(
  parameter int unsigned PDW_CYC = `MSP_PDW_CYC,
  parameter int unsigned COMPUTE_CYC = `MSP_COMPUTE_CYC,
  parameter int unsigned QUAD_BASE_CYC = `MSP_QUAD_BASE_CYC,
  parameter int unsigned FRAME_CYC = `MSP_FRAME_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pd_s,
  input wire logic [15:0] frame_period_cyc,
  output logic port_rst,
  output logic sleeping,
  output logic regs_fresh,
  output logic quad_valid,
  output logic frame_tick
);
  logic [16:0] hi_cnt_r, hi_cnt_nxt, wake_cnt_r, wake_cnt_nxt;
  logic [15:0] frm_cnt_r, frm_cnt_nxt, period;
  logic [6:0] frames_r, frames_nxt;
  logic prst_r, prst_nxt, asleep_r, asleep_nxt, wake_r, wake_nxt;
  logic fresh_r, fresh_nxt, quad_r, quad_nxt, tick_r, tick_nxt;

  // ****************************************************
  // sequencing
  // ****************************************************
  always_comb begin
    hi_cnt_nxt = 17'h00000;
    prst_nxt = 1'b0;
    asleep_nxt = asleep_r;
    wake_nxt = wake_r;
    wake_cnt_nxt = wake_cnt_r;
    frames_nxt = frames_r;
    fresh_nxt = fresh_r;
    quad_nxt = quad_r;
    // zero period means the default frame rate
    period = (frame_period_cyc != 16'h0000) ? frame_period_cyc
                                             : 16'(FRAME_CYC);
    frm_cnt_nxt = frm_cnt_r;
    tick_nxt = 1'b0;
    if (!asleep_r) begin
      if (frm_cnt_r >= period - 16'h0001) begin
        frm_cnt_nxt = 16'h0000;
        tick_nxt = 1'b1;
      end else begin
        frm_cnt_nxt = frm_cnt_r + 16'h0001;
      end
    end
    if (pd_s) begin
      // saturate at full scale so neither pulse threshold is reached twice in one pulse
      hi_cnt_nxt = (hi_cnt_r == 17'h1FFFF) ? hi_cnt_r
                                           : hi_cnt_r + 17'h00001;
    end
    if (pd_s && hi_cnt_r == 17'(`MSP_PDR_CYC - 1)) begin
      prst_nxt = 1'b1;
    end
    if (pd_s && hi_cnt_r == 17'(PDW_CYC - 1)) begin
      asleep_nxt = 1'b1;
      wake_nxt = 1'b0;
      fresh_nxt = 1'b0;
      quad_nxt = 1'b0;
    end else if (!pd_s && asleep_r) begin
      asleep_nxt = 1'b0;
      wake_nxt = 1'b1;
      wake_cnt_nxt = 17'h00000;
      frames_nxt = 7'h00;
    end else if (wake_r) begin
      if (wake_cnt_r != 17'h1FFFF) begin
        wake_cnt_nxt = wake_cnt_r + 17'h00001;
      end
      if (wake_cnt_r == 17'(COMPUTE_CYC - 1)) begin
        fresh_nxt = 1'b1;
      end
      if (wake_cnt_r >= 17'(QUAD_BASE_CYC) && tick_r) begin
        if (frames_r == 7'(`MSP_QUAD_FRAMES - 1)) begin
          quad_nxt = 1'b1;
          fresh_nxt = 1'b1;
          wake_nxt = 1'b0;
        end else begin
          frames_nxt = frames_r + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt_r <= 17'h00000;
      wake_cnt_r <= 17'h00000;
      frm_cnt_r <= 16'h0000;
      frames_r <= 7'h00;
      prst_r <= 1'b0;
      asleep_r <= 1'b0;
      wake_r <= 1'b0;
      fresh_r <= 1'b1;
      quad_r <= 1'b1;
      tick_r <= 1'b0;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
      wake_cnt_r <= wake_cnt_nxt;
      frm_cnt_r <= frm_cnt_nxt;
      frames_r <= frames_nxt;
      prst_r <= prst_nxt;
      asleep_r <= asleep_nxt;
      wake_r <= wake_nxt;
      fresh_r <= fresh_nxt;
      quad_r <= quad_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign port_rst = prst_r;
  assign sleeping = asleep_r;
  assign regs_fresh = fresh_r;
  assign quad_valid = quad_r;
  assign frame_tick = tick_r;

  // ****************************************************
  // checks
  // ****************************************************
  // sleep entry time
  property p_sleep_entry;
    @(posedge clk) disable iff (!rst_n)
      $rose(asleep_r) |-> $past(pd_s) && $past(hi_cnt_r) == 17'(PDW_CYC - 1);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entered at wrong time");
  property p_port_rst;
    @(posedge clk) disable iff (!rst_n)
      prst_r |-> $past(pd_s) && $past(hi_cnt_r) == 17'(`MSP_PDR_CYC - 1);
  endproperty
  a_port_rst: assert property (p_port_rst)
    else $error("port reset without full pulse");
  property p_fresh;
    @(posedge clk) disable iff (!rst_n)
      wake_r && !asleep_nxt && wake_cnt_r == 17'(COMPUTE_CYC - 1) |=> fresh_r;
  endproperty
  a_fresh: assert property (p_fresh)
    else $error("registers not refreshed in time");
  property p_quad;
    @(posedge clk) disable iff (!rst_n)
      $rose(quad_r) |-> $past(frames_r) == 7'(`MSP_QUAD_FRAMES - 1)
        && $past(wake_cnt_r) >= 17'(QUAD_BASE_CYC);
  endproperty
  a_quad: assert property (p_quad)
    else $error("quadrature valid too early");
  property p_frame;
    @(posedge clk) disable iff (!rst_n)
      asleep_r && $past(asleep_r) |-> !tick_r;
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame tick while asleep");
endmodule : msp_power_seq

// >>> verilog/msp_serial_port.sv
// two-wire serial port of the motion sensor with power-down control
`include "msp_defines.svh"
module msp_serial_port #(
  parameter int unsigned PDW_CYC = `MSP_PDW_CYC,
  parameter int unsigned COMPUTE_CYC = `MSP_COMPUTE_CYC,
  parameter int unsigned QUAD_BASE_CYC = `MSP_QUAD_BASE_CYC,
  parameter int unsigned FRAME_CYC = `MSP_FRAME_CYC,
  parameter int unsigned WD_CYC = `MSP_WD_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  input wire logic power_down_input,
  input wire logic [15:0] frame_period_cyc,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr_en,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rdata,
  output logic sleeping,
  output logic regs_fresh,
  output logic quad_valid,
  output logic frame_tick
);
  logic [2:0] sclk_q_r;
  logic [1:0] sdio_q_r, pd_q_r;
  logic sclk_rise, sclk_fall, sdio_s, pd_s, port_rst, wd_expire;
  logic port_clear, busy;
  logic [7:0] byte_in;
  msp_pkg::msp_state_e state_r, state_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] shift_r, shift_nxt, wdata_r, wdata_nxt;
  logic [6:0] addr_r, addr_nxt;
  logic [11:0] prep_cnt_r, prep_cnt_nxt;
  logic [24:0] wd_cnt_r, wd_cnt_nxt;
  logic sdo_r, sdo_nxt, oe_r, oe_nxt;
  logic wr_en_r, wr_en_nxt, rd_en_r, rd_en_nxt;

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  // two core clocks
  // pins are asynchronous to clk; first stage is read by the second only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q_r <= 3'h0;
      sdio_q_r <= 2'h3;
      pd_q_r <= 2'h0;
    end else begin
      sclk_q_r <= {sclk_q_r[1:0], sclk};
      sdio_q_r <= {sdio_q_r[0], sdio_in};
      pd_q_r <= {pd_q_r[0], power_down_input};
    end
  end

  assign sclk_rise = sclk_q_r[1] & ~sclk_q_r[2];
  assign sclk_fall = ~sclk_q_r[1] & sclk_q_r[2];
  assign sdio_s = sdio_q_r[1];
  assign pd_s = pd_q_r[1];

  // ****************************************************
  // power-down sequencing
  // ****************************************************
  msp_power_seq #(
    .PDW_CYC(PDW_CYC),
    .COMPUTE_CYC(COMPUTE_CYC),
    .QUAD_BASE_CYC(QUAD_BASE_CYC),
    .FRAME_CYC(FRAME_CYC)
  ) u_power (
    .clk(clk),
    .rst_n(rst_n),
    .pd_s(pd_s),
    .frame_period_cyc(frame_period_cyc),
    .port_rst(port_rst),
    .sleeping(sleeping),
    .regs_fresh(regs_fresh),
    .quad_valid(quad_valid),
    .frame_tick(frame_tick)
  );

  // ****************************************************
  // transaction engine
  // ****************************************************
  // a transaction is open from its first address bit until its last bit is clocked in
  assign busy = (state_r != msp_pkg::MSP_ST_ADDR
                 && state_r != msp_pkg::MSP_ST_RHOLD)
                || bit_cnt_r != 4'h0;
  assign wd_expire = busy && wd_cnt_r == 25'(WD_CYC - 1);
  assign port_clear = port_rst || wd_expire;
  assign byte_in = {shift_r[6:0], sdio_s};

  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    prep_cnt_nxt = prep_cnt_r;
    sdo_nxt = sdo_r;
    oe_nxt = oe_r;
    wr_en_nxt = 1'b0;
    rd_en_nxt = 1'b0;
    wd_cnt_nxt = busy ? wd_cnt_r + 25'h0000001 : 25'h0000000;
    if (port_clear) begin
      state_nxt = msp_pkg::MSP_ST_ADDR;
      bit_cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
      wd_cnt_nxt = 25'h0000000;
    end else begin
      case (state_r)
        msp_pkg::MSP_ST_ADDR: begin
          // address bits clocked while power-down is high are ignored; the write data phase does not check power-down
          if (sclk_rise && !pd_s) begin
            shift_nxt = byte_in;
            if (bit_cnt_r == `MSP_LAST_BIT) begin
              bit_cnt_nxt = 4'h0;
              addr_nxt = byte_in[6:0];
              if (byte_in[`MSP_CMD_WRITE_BIT]) begin
                state_nxt = msp_pkg::MSP_ST_WDATA;
              end else begin
                state_nxt = msp_pkg::MSP_ST_PREP;
                prep_cnt_nxt = 12'h000;
                rd_en_nxt = 1'b1;
              end
            end else begin
              bit_cnt_nxt = bit_cnt_r + 4'h1;
            end
          end
        end
        msp_pkg::MSP_ST_WDATA: begin
          if (sclk_rise) begin
            shift_nxt = byte_in;
            if (bit_cnt_r == `MSP_LAST_BIT) begin
              bit_cnt_nxt = 4'h0;
              wdata_nxt = byte_in;
              wr_en_nxt = 1'b1;
              state_nxt = msp_pkg::MSP_ST_ADDR;
            end else begin
              bit_cnt_nxt = bit_cnt_r + 4'h1;
            end
          end
        end
        msp_pkg::MSP_ST_PREP: begin
          // data preparation
          // clock edges during preparation are ignored, not queued
          if (prep_cnt_r == 12'(`MSP_PREP_CYC - 1)) begin
            shift_nxt = reg_rdata;
            sdo_nxt = reg_rdata[7];
            oe_nxt = 1'b1;
            state_nxt = msp_pkg::MSP_ST_RDATA;
          end else begin
            prep_cnt_nxt = prep_cnt_r + 12'h001;
          end
        end
        msp_pkg::MSP_ST_RDATA: begin
          if (sclk_fall && bit_cnt_r != 4'h0) begin
            shift_nxt = {shift_r[6:0], 1'b0};
            sdo_nxt = shift_r[6];
          end
          if (sclk_rise) begin
            if (bit_cnt_r == `MSP_LAST_BIT) begin
              bit_cnt_nxt = 4'h0;
              state_nxt = msp_pkg::MSP_ST_RHOLD;
            end else begin
              bit_cnt_nxt = bit_cnt_r + 4'h1;
            end
          end
        end
        msp_pkg::MSP_ST_RHOLD: begin
          // release on fall
          // the last bit is held so the host can sample it late
          if (sclk_fall) begin
            oe_nxt = 1'b0;
            state_nxt = msp_pkg::MSP_ST_ADDR;
          end
        end
        default: begin
          state_nxt = msp_pkg::MSP_ST_ADDR;
          bit_cnt_nxt = 4'h0;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= msp_pkg::MSP_ST_ADDR;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      addr_r <= 7'h00;
      wdata_r <= 8'h00;
      prep_cnt_r <= 12'h000;
      wd_cnt_r <= 25'h0000000;
      sdo_r <= 1'b0;
      oe_r <= 1'b0;
      wr_en_r <= 1'b0;
      rd_en_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      prep_cnt_r <= prep_cnt_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      sdo_r <= sdo_nxt;
      oe_r <= oe_nxt;
      wr_en_r <= wr_en_nxt;
      rd_en_r <= rd_en_nxt;
    end
  end

  assign sdio_out = sdo_r;
  assign sdio_oe = oe_r;
  assign reg_addr = addr_r;
  assign reg_wdata = wdata_r;
  assign reg_wr_en = wr_en_r;
  assign reg_rd_en = rd_en_r;

  // ****************************************************
  // checks
  // ****************************************************
  // drive window only
  property p_oe_window;
    @(posedge clk) disable iff (!rst_n)
      oe_r |-> state_r == msp_pkg::MSP_ST_RDATA
        || state_r == msp_pkg::MSP_ST_RHOLD;
  endproperty
  a_oe_window: assert property (p_oe_window)
    else $error("data line driven outside read data");
  property p_prep;
    @(posedge clk) disable iff (!rst_n)
      $rose(oe_r) |-> $past(prep_cnt_r) == 12'(`MSP_PREP_CYC - 1)
        && $past(state_r) == msp_pkg::MSP_ST_PREP;
  endproperty
  a_prep: assert property (p_prep)
    else $error("read data driven before preparation ended");
  property p_watchdog;
    @(posedge clk) disable iff (!rst_n)
      wd_expire |=> state_r == msp_pkg::MSP_ST_ADDR && bit_cnt_r == 4'h0
        && !oe_r && wd_cnt_r == 25'h0000000;
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("watchdog did not reset the port");
  property p_pd_reset;
    @(posedge clk) disable iff (!rst_n)
      port_rst |=> state_r == msp_pkg::MSP_ST_ADDR && !oe_r
        && $stable(addr_r) && $stable(wdata_r);
  endproperty
  a_pd_reset: assert property (p_pd_reset)
    else $error("port reset failed or disturbed data");
  property p_write;
    @(posedge clk) disable iff (!rst_n)
      wr_en_r |-> $past(state_r) == msp_pkg::MSP_ST_WDATA
        && $past(bit_cnt_r) == `MSP_LAST_BIT && $past(sclk_rise) ##1 !wr_en_r;
  endproperty
  a_write: assert property (p_write)
    else $error("write strobe without full data byte");
  property p_read;
    @(posedge clk) disable iff (!rst_n)
      rd_en_r |-> !$past(byte_in[7]) && state_r == msp_pkg::MSP_ST_PREP;
  endproperty
  a_read: assert property (p_read)
    else $error("read request without read command");
  property p_bit_rise;
    @(posedge clk) disable iff (!rst_n)
      $changed(bit_cnt_r) && !$past(port_clear) |-> $past(sclk_rise);
  endproperty
  a_bit_rise: assert property (p_bit_rise)
    else $error("bit counted without serial clock rise");
endmodule : msp_serial_port

// >>> sim/msp_host_model.sv
// host side model: drives serial clock, data line and power-down pin
module msp_host_model (
  input wire logic sdio_out,
  input wire logic sdio_oe,
  output logic sclk,
  output wire logic sdio_in,
  output logic power_down_input
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************
  // line state
  // ************************************
  // 400 ns period, well below a quarter of core clock
  localparam int T_LO = 250;
  localparam int T_HI = 150;
  logic host_oe = 1'b0;
  logic host_d = 1'b0;
  logic junk = 1'b0;
  initial begin
    sclk = 1'b0;
    power_down_input = 1'b0;
  end
  // released line toggles so a stale bit never reads as valid
  always #50 junk = ~junk;
  assign sdio_in = (sdio_oe === 1'b1) ? sdio_out : (host_oe ? host_d : junk);
  // ************************************
  // commands
  // ************************************
  // msb first, change on fall
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      host_oe = 1'b1;
      host_d = b[i];
      #T_LO sclk = 1'b1;
      #T_HI sclk = 1'b0;
    end
  endtask : send_bits
  task automatic part_cmd(input logic [7:0] b, input int n);
    send_bits(b, n);
    host_oe = 1'b0;
  endtask : part_cmd
  task automatic write_cmd(input logic [6:0] a, input logic [7:0] d);
    wait (power_down_input == 1'b0);
    send_bits({1'b1, a}, 8);
    send_bits(d, 8);
    host_oe = 1'b0;
    #100000;
  endtask : write_cmd
  task automatic read_cmd(input logic [6:0] a, output logic [7:0] d);
    wait (power_down_input == 1'b0);
    send_bits({1'b0, a}, 8);
    host_oe = 1'b0;
    // data clocks held off for preparation
    #101000;
    for (int i = 7; i >= 0; i--) begin
      #T_LO sclk = 1'b1;
      d[i] = sdio_in;
      #T_HI sclk = 1'b0;
    end
    #150;
  endtask : read_cmd
  task automatic set_pd(input logic v);
    power_down_input = v;
  endtask : set_pd
endmodule : msp_host_model

// >>> sim/msp_serial_port_bench.sv
// self-checking bench of the serial port and power-down logic
`include "msp_defines.svh"
module msp_serial_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************
  // setup
  // ************************************
  localparam int PDW = 40;
  localparam int COMP = 60;
  localparam int QBASE = 30;
  // longer than the sleep scenario, so only the pulse clears its stale byte
  localparam int WD = 4000;
  localparam int FRM = 25;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, sdio_in, sdio_out, sdio_oe, pd;
  logic [15:0] fp = 16'h000A;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_wr_en, reg_rd_en, sleeping, regs_fresh, quad_valid, frame_tick;
  logic [7:0] user_mem [128];
  logic [7:0] exp_mem [128];
  logic [6:0] exp_qa [$];
  logic [7:0] exp_qd [$];
  logic [6:0] last_a = 7'h00;
  int num_errors = 0;
  int checked = 0;
  int prep_cnt = 0;
  int n;
  always #25 clk = ~clk;
  msp_serial_port #(.PDW_CYC(PDW), .COMPUTE_CYC(COMP),
    .QUAD_BASE_CYC(QBASE), .FRAME_CYC(FRM), .WD_CYC(WD))
    u_dut (.clk(clk), .rst_n(rst_n),
    .sclk(sclk), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .power_down_input(pd), .frame_period_cyc(fp), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .sleeping(sleeping), .regs_fresh(regs_fresh),
    .quad_valid(quad_valid), .frame_tick(frame_tick));
  msp_host_model u_host (.sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .sclk(sclk), .sdio_in(sdio_in), .power_down_input(pd));
  assign reg_rdata = user_mem[reg_addr];
  // ************************************
  // helpers
  // ************************************
  task automatic check(input logic [31:0] seen, exp, input string msg);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  task automatic cycles(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask : cycles
  function automatic logic sig(input int w);
    case (w)
      0: return frame_tick;
      1: return sleeping;
      2: return regs_fresh;
      default: return quad_valid;
    endcase
  endfunction : sig
  task automatic wait_hi(input int w, output int k);
    k = 0;
    do begin
      cycles(1);
      k++;
    end while (sig(w) !== 1'b1 && k < 3000);
  endtask : wait_hi
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    exp_mem[a] = d;
    exp_qa.push_back(a);
    exp_qd.push_back(d);
    last_a = a;
    u_host.write_cmd(a, d);
  endtask : wr
  task automatic rd(input logic [6:0] a);
    logic [7:0] d;
    last_a = a;
    u_host.read_cmd(a, d);
    check(d, exp_mem[a], "read data");
    #300;
    check(sdio_oe, 1'b0, "data line still driven");
  endtask : rd
  // user side register file and write/prep monitors
  // sampled on the falling edge, where the outputs have settled
  always @(negedge clk) begin
    if (reg_wr_en === 1'b1) begin
      user_mem[reg_addr] <= reg_wdata;
      if (exp_qa.size() == 0) begin
        check(1, 0, "unexpected write");
      end else begin
        check(reg_addr, exp_qa.pop_front(), "write address");
        check(reg_wdata, exp_qd.pop_front(), "write data");
      end
    end
    if (reg_rd_en === 1'b1) begin
      prep_cnt <= 1;
    end else if (prep_cnt > 0 && sdio_oe !== 1'b1) begin
      prep_cnt <= prep_cnt + 1;
    end else if (prep_cnt > 0) begin
      check(prep_cnt, `MSP_PREP_CYC, "preparation time");
      prep_cnt <= 0;
    end
  end
  initial begin
    #4000000;
    num_errors++;
    print_verdict();
  end
  // ************************************
  // scenarios
  // ************************************
  initial begin
    void'($urandom(98936));
    for (int i = 0; i < 128; i++) begin
      user_mem[i] = 8'($urandom);
      exp_mem[i] = user_mem[i];
    end
    fp = 16'(8 + $urandom % 8);
    repeat (20) @(posedge clk);
    #5 rst_n = 1'b1;
    check({sdio_oe, sleeping, regs_fresh, quad_valid}, 4'h3, "reset");
    wait_hi(0, n);
    wait_hi(0, n);
    check(n, fp, "frame period");
    wr(7'h7F, 8'($urandom));
    wr(7'h00, 8'($urandom));
    for (int i = 0; i < 2; i++) begin
      wr(7'($urandom), 8'($urandom));
    end
    rd(7'h7F);
    rd(7'h00);
    wr(7'h15, 8'hA5);
    rd(7'h15);
    // abandoned address then port reset by a long pulse
    u_host.part_cmd(8'h8A, 5);
    check(reg_addr, last_a, "address moved on partial byte");
    u_host.set_pd(1'b1);
    wait_hi(1, n);
    check(n >= PDW && n <= PDW + 4, 1, "sleep entry");
    check({regs_fresh, quad_valid}, 2'h0, "flags in sleep");
    n = 0;
    for (int i = 0; i < 2200 - PDW; i++) begin
      cycles(1);
      n += (frame_tick === 1'b1);
    end
    check(n, 0, "frames while asleep");
    u_host.set_pd(1'b0);
    check(reg_addr, last_a, "address after port reset");
    check(sdio_oe, 1'b0, "line after port reset");
    wait_hi(2, n);
    check(n >= COMP && n <= COMP + 4, 1, "fresh data delay");
    wait_hi(3, n);
    n += COMP;
    check(n >= QBASE + 74 * fp && n <= QBASE + 76 * fp + 8, 1,
      "quadrature delay");
    wr(7'h2C, 8'($urandom));
    rd(7'h2C);
    // short pulse resets nothing of the sleep state
    u_host.set_pd(1'b1);
    n = 0;
    for (int i = 0; i < PDW - 20; i++) begin
      cycles(1);
      n += (sleeping === 1'b1);
    end
    u_host.set_pd(1'b0);
    cycles(10);
    check(n + sleeping, 0, "short pulse slept");
    // stalled transaction cleared by the watchdog
    u_host.part_cmd(8'h83, 3);
    cycles(WD + 20);
    wr(7'h41, 8'($urandom));
    rd(7'h41);
    check(exp_qa.size(), 0, "writes missing");
    // zero period selects the default frame length
    fp = 16'h0000;
    wait_hi(0, n);
    wait_hi(0, n);
    check(n, FRM, "default frame period");
    print_verdict();
  end
endmodule : msp_serial_port_bench
